// ### design/mmd_mem_end.sv
// memory map end: data ram, extended ram, program flash and fetch counter
`timescale 1ns/10ps
module mmd_mem_end #(
  parameter int EXT_WAIT_CYC = mmd_pkg::EXT_RAM_WAIT
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  mmd_if.mem link,
  input wire logic reset_event,
  input wire logic dbg_wr,
  input wire logic [13:0] dbg_addr,
  input wire logic [7:0] dbg_data,
  output logic sfr_rd,
  output logic sfr_wr,
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  output logic [7:0] sfr_mask,
  input wire logic [7:0] sfr_rdata
);
  import mmd_pkg::*;

  logic [7:0] internal_data_ram [INT_RAM_BYTES];
  logic [7:0] extended_data_ram [EXT_RAM_BYTES];
  logic [7:0] pf_mem [PF_BYTES];

  logic busy_q;
  logic [3:0] wait_q;
  logic [7:0] hold_q;
  logic err_hold_q;
  logic sfr_pend_q;
  logic sfr_isbit_q;
  logic [2:0] sfr_bit_q;
  logic resp_valid_q;
  logic [7:0] rdata_q;
  logic resp_err_q;
  logic [13:0] pc_q;
  logic sfr_rd_q;
  logic sfr_wr_q;
  logic [7:0] sfr_addr_q;
  logic [7:0] sfr_wdata_q;
  logic [7:0] sfr_mask_q;

  logic take;
  logic [15:0] cur_ptr;
  logic [9:0] xaddr;
  logic [13:0] taddr;
  logic [13:0] paddr;
  logic [7:0] a8;
  logic [7:0] reg_byte;
  logic [7:0] bit_byte;
  logic [2:0] bit_pos;
  logic dir_sfr;
  logic bit_sfr;
  logic is_dir;
  logic is_bit;
  logic is_rd;
  logic to_sfr;
  logic isp_ok;
  logic irq_ok;
  logic [7:0] rd_byte;
  logic req_err;
  logic [3:0] lat;

  // one request at a time; a busy wait for slow targets holds ready low
  assign take = link.req && !busy_q;
  assign link.ready = !busy_q;
  assign link.resp_valid = resp_valid_q;
  assign link.rdata = rdata_q;
  assign link.resp_err = resp_err_q;
  assign link.pc = pc_q;
  assign sfr_rd = sfr_rd_q;
  assign sfr_wr = sfr_wr_q;
  assign sfr_addr = sfr_addr_q;
  assign sfr_wdata = sfr_wdata_q;
  assign sfr_mask = sfr_mask_q;

  // pointer selection and address folding
  assign cur_ptr = link.dp_sel ? link.dp1 : link.dp0;
  assign xaddr = cur_ptr[EXT_RAM_AW-1:0];
  assign taddr = cur_ptr[PF_AW-1:0];
  assign paddr = link.addr[PF_AW-1:0];
  assign a8 = link.addr[7:0];

  // working register byte from bank bits and register number
  assign reg_byte = {3'b000, link.bank, link.addr[2:0]};

  // bit address split; the upper half goes to bit-addressable special regs
  assign bit_byte = mmd_bit_byte(a8);
  assign bit_pos = a8[2:0];
  assign bit_sfr = a8 > BIT_ADDR_LAST;

  // direct access above the low half leaves the ram for special space
  assign dir_sfr = a8 >= DIRECT_SFR_BASE;

  // operation class decode
  assign is_dir = (link.op == OP_DIR_RD) || (link.op == OP_DIR_WR);
  assign is_bit = (link.op == OP_BIT_RD) || (link.op == OP_BIT_WR);
  assign is_rd = (link.op == OP_DIR_RD) || (link.op == OP_BIT_RD);
  assign to_sfr = (is_dir && dir_sfr) || (is_bit && bit_sfr);
  assign isp_ok = mmd_in_isp(link.addr);
  assign irq_ok = link.addr[4:0] < IRQ_LIMIT;

  // read data selected from the addressed store
  always_comb begin
    rd_byte = 8'h00;
    unique case (link.op)
      OP_DIR_RD, OP_IND_RD: begin
        rd_byte = internal_data_ram[a8];
      end
      OP_REG_RD: begin
        rd_byte = internal_data_ram[reg_byte];
      end
      OP_BIT_RD: begin
        rd_byte = {7'h00, internal_data_ram[bit_byte][bit_pos]};
      end
      OP_XR_RD: begin
        rd_byte = extended_data_ram[xaddr];
      end
      OP_FETCH: begin
        rd_byte = pf_mem[pc_q];
      end
      OP_TABLE: begin
        rd_byte = pf_mem[taddr];
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
  end

  // refused requests: bad source number, update outside the open area
  always_comb begin
    req_err = 1'b0;
    if (link.op == OP_IRQ) begin
      req_err = !irq_ok;
    end else if (link.op == OP_ISP_WR) begin
      req_err = !isp_ok;
    end
  end

  // extended ram pays extra wait cycles, special space one for its port
  always_comb begin
    lat = 4'h0;
    if (to_sfr) begin
      lat = SFR_WAIT;
    end else if ((link.op == OP_XR_RD) || (link.op == OP_XR_WR)) begin
      lat = 4'(EXT_WAIT_CYC);
    end
  end

  // internal data ram writes; only the low half cells serve both address modes
  always_ff @(posedge clk_sys) begin
    if (take) begin
      unique case (link.op)
        OP_DIR_WR: begin
          if (!dir_sfr) begin
            internal_data_ram[a8] <= link.wdata;
          end
        end
        OP_IND_WR: begin
          internal_data_ram[a8] <= link.wdata;
        end
        OP_REG_WR: begin
          internal_data_ram[reg_byte] <= link.wdata;
        end
        OP_BIT_WR: begin
          if (!bit_sfr) begin
            internal_data_ram[bit_byte][bit_pos] <= link.bitval;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // extended ram is only touched by the external move write
  always_ff @(posedge clk_sys) begin
    if (take && (link.op == OP_XR_WR)) begin
      extended_data_ram[xaddr] <= link.wdata;
    end
  end

  // flash writes: debug port is unrestricted and wins on the same byte
  always_ff @(posedge clk_sys) begin
    if (take && (link.op == OP_ISP_WR) && isp_ok) begin
      pf_mem[paddr] <= link.wdata;
    end
    if (dbg_wr) begin
      pf_mem[dbg_addr] <= dbg_data;
    end
  end

  // fetch counter; any reset source restarts at the reset vector
  always_ff @(posedge clk_sys) begin
    if (!reset_n || reset_event) begin
      pc_q <= RESET_VECTOR;
    end else if (take) begin
      if (link.op == OP_FETCH) begin
        pc_q <= pc_q + 14'h0001;
      end else if (link.op == OP_JUMP) begin
        pc_q <= paddr;
      end else if ((link.op == OP_IRQ) && irq_ok) begin
        pc_q <= VECTOR_TABLE[link.addr[4:0]];
      end
    end
  end

  // special space port is registered; bit writes go out as a lane mask
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      sfr_rd_q <= 1'b0;
      sfr_wr_q <= 1'b0;
      sfr_addr_q <= 8'h00;
      sfr_wdata_q <= 8'h00;
      sfr_mask_q <= 8'h00;
    end else begin
      sfr_rd_q <= take && to_sfr && is_rd;
      sfr_wr_q <= take && to_sfr && !is_rd;
      if (take && to_sfr) begin
        sfr_addr_q <= is_bit ? {a8[7:3], 3'b000} : a8;
        sfr_wdata_q <= is_bit ? {8{link.bitval}} : link.wdata;
        sfr_mask_q <= is_bit ? (8'h01 << bit_pos) : 8'hff;
      end
    end
  end

  // answer sequencing: immediate answer or count down the wait
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      busy_q <= 1'b0;
      wait_q <= 4'h0;
      hold_q <= 8'h00;
      err_hold_q <= 1'b0;
      sfr_pend_q <= 1'b0;
      sfr_isbit_q <= 1'b0;
      sfr_bit_q <= 3'h0;
      resp_valid_q <= 1'b0;
      rdata_q <= 8'h00;
      resp_err_q <= 1'b0;
    end else begin
      resp_valid_q <= 1'b0;
      if (take) begin
        sfr_pend_q <= to_sfr && is_rd;
        sfr_isbit_q <= is_bit;
        sfr_bit_q <= bit_pos;
        if (lat == 4'h0) begin
          resp_valid_q <= 1'b1;
          rdata_q <= rd_byte;
          resp_err_q <= req_err;
        end else begin
          busy_q <= 1'b1;
          wait_q <= lat;
          hold_q <= rd_byte;
          err_hold_q <= req_err;
        end
      end else if (busy_q) begin
        if (wait_q == 4'h1) begin
          busy_q <= 1'b0;
          resp_valid_q <= 1'b1;
          resp_err_q <= err_hold_q;
          if (sfr_pend_q) begin
            rdata_q <= sfr_isbit_q ? {7'h00, sfr_rdata[sfr_bit_q]} : sfr_rdata;
          end else begin
            rdata_q <= hold_q;
          end
        end else begin
          wait_q <= wait_q - 4'h1;
        end
      end
    end
  end

endmodule

// ### shared/mmd_pkg.sv
// constants, types and decode helpers for the memory map decoder and its cpu end
package mmd_pkg;

  localparam int INT_RAM_AW = 8;
  localparam int EXT_RAM_AW = 10;
  localparam int PF_AW = 14;
  localparam int INT_RAM_BYTES = 256;
  localparam int EXT_RAM_BYTES = 1024;
  localparam int PF_BYTES = 16384;

  localparam logic [7:0] DIRECT_SFR_BASE = 8'h80;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  localparam logic [7:0] BIT_ADDR_LAST = 8'h7f;

  localparam logic [13:0] RESET_VECTOR = 14'h0000;
  localparam logic [13:0] ISP_FIRST = 14'h00ec;
  localparam logic [13:0] ISP_LAST = 14'h3fdf;
  localparam logic [13:0] NO_ISP_FIRST = 14'h3fe0;
  localparam logic [13:0] RESERVED_FIRST = 14'h3ff6;

  // answer latency in clk_sys cycles beyond the one-cycle base
  localparam int EXT_RAM_WAIT = 1;
  localparam logic [3:0] SFR_WAIT = 4'h1;

  localparam int IRQ_COUNT = 19;
  localparam logic [4:0] IRQ_LIMIT = 5'h13;

  // order: ext0, timer0, ext1, timer1, serial, timer2, i2c, spi,
  // compare ch0..3, pwm1..3, converter, comparator0, comparator1, ext2
  localparam logic [13:0] VECTOR_TABLE [IRQ_COUNT] = '{
    14'h0003, 14'h000b, 14'h0013, 14'h001b, 14'h0023, 14'h002b,
    14'h0043, 14'h004b, 14'h0053, 14'h005b, 14'h0063, 14'h006b,
    14'h0083, 14'h008b, 14'h0093, 14'h009b, 14'h00a3, 14'h00ab,
    14'h00eb
  };

  typedef enum logic [3:0] {
    OP_DIR_RD, OP_DIR_WR, OP_IND_RD, OP_IND_WR,
    OP_REG_RD, OP_REG_WR, OP_BIT_RD, OP_BIT_WR,
    OP_XR_RD, OP_XR_WR, OP_FETCH, OP_TABLE,
    OP_JUMP, OP_IRQ, OP_ISP_WR
  } mmd_op_t;

  // byte that holds a bit address of the low bit area
  function automatic logic [7:0] mmd_bit_byte(input logic [7:0] b);
    return BIT_AREA_BASE + {4'h0, b[6:3]};
  endfunction

  // true inside the program area that self updates may rewrite
  function automatic logic mmd_in_isp(input logic [15:0] a);
    return (a >= {2'b00, ISP_FIRST}) && (a <= {2'b00, ISP_LAST});
  endfunction

endpackage

// ### shared/mmd_if.sv
// link between the cpu end and the memory map end
`timescale 1ns/10ps
interface mmd_if;
  logic req;
  logic ready;
  mmd_pkg::mmd_op_t op;
  logic [15:0] addr;
  logic [7:0] wdata;
  logic bitval;
  logic [1:0] bank;
  logic [15:0] dp0;
  logic [15:0] dp1;
  logic dp_sel;
  logic resp_valid;
  logic [7:0] rdata;
  logic resp_err;
  logic [13:0] pc;

  modport cpu (
    output req, op, addr, wdata, bitval, bank, dp0, dp1, dp_sel,
    input ready, resp_valid, rdata, resp_err, pc
  );

  modport mem (
    input req, op, addr, wdata, bitval, bank, dp0, dp1, dp_sel,
    output ready, resp_valid, rdata, resp_err, pc
  );
endinterface

// ### design/mmd_cpu_end.sv
// cpu end: issues one memory request at a time and returns the answer
`timescale 1ns/10ps
module mmd_cpu_end (
  input wire logic clk_sys,
  input wire logic reset_n,
  mmd_if.cpu link,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire mmd_pkg::mmd_op_t cmd_op,
  input wire logic [15:0] cmd_addr,
  input wire logic [7:0] cmd_wdata,
  input wire logic cmd_bit,
  input wire logic bank_select_lo,
  input wire logic bank_select_hi,
  input wire logic [15:0] dp0,
  input wire logic [15:0] dp1,
  input wire logic dp_sel,
  output logic done_valid,
  output logic [7:0] done_data,
  output logic done_err,
  output logic [13:0] fetch_addr
);
  import mmd_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_REQ, H_WAIT} mmd_hstate_t;

  mmd_hstate_t state_q;
  mmd_op_t op_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic bit_q;
  logic [1:0] bank_q;
  logic [15:0] dp0_q;
  logic [15:0] dp1_q;
  logic dp_sel_q;
  logic done_valid_q;
  logic [7:0] done_data_q;
  logic done_err_q;
  logic refuse;

  assign cmd_ready = (state_q == H_IDLE);
  assign link.req = (state_q == H_REQ);
  assign link.op = op_q;
  assign link.addr = addr_q;
  assign link.wdata = wdata_q;
  assign link.bitval = bit_q;
  assign link.bank = bank_q;
  assign link.dp0 = dp0_q;
  assign link.dp1 = dp1_q;
  assign link.dp_sel = dp_sel_q;
  assign done_valid = done_valid_q;
  assign done_data = done_data_q;
  assign done_err = done_err_q;
  assign fetch_addr = link.pc;

  // updates aimed at the vector area or the protected top are stopped before the link
  assign refuse = (cmd_op == OP_ISP_WR) && !mmd_in_isp(cmd_addr);

  // bank and pointer state is copied each cycle, so it lags its inputs by one
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      bank_q <= 2'b00;
      dp0_q <= 16'h0000;
      dp1_q <= 16'h0000;
      dp_sel_q <= 1'b0;
    end else begin
      bank_q <= {bank_select_hi, bank_select_lo};
      dp0_q <= dp0;
      dp1_q <= dp1;
      dp_sel_q <= dp_sel;
    end
  end

  // request sequencer: idle, hold request until taken, wait for the answer
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state_q <= H_IDLE;
      op_q <= OP_FETCH;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      bit_q <= 1'b0;
      done_valid_q <= 1'b0;
      done_data_q <= 8'h00;
      done_err_q <= 1'b0;
    end else begin
      done_valid_q <= 1'b0;
      unique case (state_q)
        H_IDLE: begin
          if (cmd_valid && refuse) begin
            done_valid_q <= 1'b1;
            done_data_q <= 8'h00;
            done_err_q <= 1'b1;
          end else if (cmd_valid) begin
            op_q <= cmd_op;
            addr_q <= cmd_addr;
            wdata_q <= cmd_wdata;
            bit_q <= cmd_bit;
            state_q <= H_REQ;
          end
        end
        H_REQ: begin
          if (link.ready) begin
            state_q <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (link.resp_valid) begin
            done_valid_q <= 1'b1;
            done_data_q <= link.rdata;
            done_err_q <= link.resp_err;
            state_q <= H_IDLE;
          end
        end
      endcase
    end
  end

endmodule

// ### sim/mmd_link_sva.sv
// concurrent checks on the link between the cpu end and the memory map end
`timescale 1ns/10ps
module mmd_link_sva (
  input logic clk_sys,
  input logic reset_n,
  input logic req,
  input logic ready,
  input mmd_pkg::mmd_op_t op,
  input logic [15:0] addr,
  input logic resp_valid,
  input logic resp_err,
  input logic [13:0] pc
);
  import mmd_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic take;
  // a request is taken only on an edge with both sides willing
  assign take = req && ready;
  // one wait state: link busy and silent for a cycle, then the answer
  sequence one_wait_s;
    !resp_valid && !ready ##1 resp_valid && ready;
  endsequence
  sequence irq_ok_s;
    take && op == OP_IRQ && addr[4:0] < IRQ_LIMIT;
  endsequence
  chk_ind_answer: assert property (take && op == OP_IND_RD |=> resp_valid)
    else $error("indirect read answer missing");
  chk_sfr_wait: assert property (take && op inside {OP_DIR_RD, OP_DIR_WR} && addr[7]
    |=> one_wait_s) else $error("direct upper access not sent with one wait");
  chk_ext_wait: assert property (take && op inside {OP_XR_RD, OP_XR_WR}
    |=> one_wait_s) else $error("extended access not answered after one wait");
  chk_ready_bound: assert property (!ready |-> ##[1:2] ready)
    else $error("link stayed busy too long");
  chk_irq_vector: assert property (irq_ok_s |=>
    pc == VECTOR_TABLE[$past(addr[4:0])] && !resp_err) else $error("wrong vector loaded");
  chk_irq_refuse: assert property (take && op == OP_IRQ && addr[4:0] >= IRQ_LIMIT
    |=> resp_valid && resp_err && $stable(pc)) else $error("bad source not refused");
  chk_pc_reset: assert property ($rose(reset_n) |-> pc == RESET_VECTOR)
    else $error("counter not at reset vector after reset");
  chk_jump_load: assert property (take && op == OP_JUMP |=> pc == $past(addr[13:0]))
    else $error("jump target not loaded");
  chk_fetch_step: assert property (take && op == OP_FETCH
    |=> pc == $past(pc) + 14'h0001) else $error("fetch counter did not step");
  chk_isp_answer: assert property (take && op == OP_ISP_WR |=> resp_valid)
    else $error("self update not answered");
endmodule

// ### sim/mcu_memory_map_decode_tb.sv
// self-checking bench joining the cpu end and the memory map end
`timescale 1ns/10ps
module mcu_memory_map_decode_tb;
  import mmd_pkg::*;
  logic clk_sys, reset_n, cmd_valid, cmd_ready, cmd_bit, bank_select_lo, bank_select_hi;
  logic dp_sel, done_valid, done_err, reset_event, dbg_wr, sfr_rd, sfr_wr;
  logic [15:0] cmd_addr, dp0, dp1;
  logic [13:0] fetch_addr, dbg_addr;
  logic [7:0] cmd_wdata, done_data, dbg_data, sfr_addr, sfr_wdata, sfr_mask, sfr_rdata;
  logic [7:0] sw_d, sw_m, sr_a;
  mmd_op_t cmd_op;
  int n_fail, n_tests;
  // own copy of the vectors, kept apart from the package table
  logic [13:0] vec [19] = '{14'h0003, 14'h000b, 14'h0013, 14'h001b, 14'h0023, 14'h002b,
    14'h0043, 14'h004b, 14'h0053, 14'h005b, 14'h0063, 14'h006b, 14'h0083, 14'h008b,
    14'h0093, 14'h009b, 14'h00a3, 14'h00ab, 14'h00eb};
  logic [15:0] ia [6] = '{16'h00eb, 16'h00ec, 16'h3fdf, 16'h3fe0, 16'h3ff6, 16'h3fff};
  logic [5:0] ie = 6'b111001;
  mmd_if lnk();
  mmd_mem_end u_mmd_mem_end(.clk_sys, .reset_n, .link(lnk), .reset_event, .dbg_wr,
    .dbg_addr, .dbg_data, .sfr_rd, .sfr_wr, .sfr_addr, .sfr_wdata, .sfr_mask, .sfr_rdata);
  mmd_cpu_end u_mmd_cpu_end(.clk_sys, .reset_n, .link(lnk), .cmd_valid, .cmd_ready,
    .cmd_op, .cmd_addr, .cmd_wdata, .cmd_bit, .bank_select_lo, .bank_select_hi, .dp0,
    .dp1, .dp_sel, .done_valid, .done_data, .done_err, .fetch_addr);
  mmd_link_sva u_mmd_link_sva(.clk_sys, .reset_n, .req(lnk.req), .ready(lnk.ready),
    .op(lnk.op), .addr(lnk.addr), .resp_valid(lnk.resp_valid), .resp_err(lnk.resp_err),
    .pc(lnk.pc));
  // special register file stand-in: answer depends on the address, so a wrong one shows
  assign sfr_rdata = sfr_addr ^ 8'h66;
  // remember the last special register write and the last read address
  always @(posedge clk_sys) begin
    if (sfr_wr === 1'b1) begin
      sw_d <= sfr_wdata;
      sw_m <= sfr_mask;
    end
    if (sfr_rd === 1'b1) begin
      sr_a <= sfr_addr;
    end
  end
  initial begin
    clk_sys = 0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one command through the cpu end, waiting for its completion pulse
  task automatic cmd(input mmd_op_t o, input logic [15:0] a, input logic [7:0] d,
                     input logic b);
    int k;
    @(negedge clk_sys);
    cmd_valid = 1;
    cmd_op = o;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_bit = b;
    while (cmd_ready !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
    cmd_valid = 0;
    k = 0;
    while (done_valid !== 1'b1 && k < 20) begin
      @(negedge clk_sys);
      k++;
    end
    if (k == 20) chk("done_valid", 16'h0000, 16'h0001);
  endtask
  task automatic rd(input mmd_op_t o, input logic [15:0] a, input logic [7:0] e);
    cmd(o, a, 8'h00, 1'b0);
    chk("done_data", {8'h00, done_data}, {8'h00, e});
  endtask
  task automatic dbg(input logic [13:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    dbg_wr = 1;
    dbg_addr = a;
    dbg_data = d;
    @(negedge clk_sys);
    dbg_wr = 0;
  endtask
  // long enough for every test several times over
  initial begin
    #(20 * 8000);
    n_fail++;
    give_verdict;
  end
  initial begin
    reset_n = 0;
    cmd_valid = 0;
    cmd_op = OP_IND_RD;
    cmd_addr = 0;
    cmd_wdata = 0;
    cmd_bit = 0;
    {bank_select_hi, bank_select_lo} = 2'b00;
    dp0 = 0;
    dp1 = 0;
    dp_sel = 0;
    reset_event = 0;
    dbg_wr = 0;
    dbg_addr = 0;
    dbg_data = 0;
    repeat (2) @(negedge clk_sys);
    reset_n = 1;
    // data ram: low half shared, upper half split by mode
    cmd(OP_IND_WR, 16'h0045, 8'ha5, 1'b0);
    rd(OP_DIR_RD, 16'h0045, 8'ha5);
    cmd(OP_DIR_WR, 16'h007f, 8'h3c, 1'b0);
    rd(OP_IND_RD, 16'h007f, 8'h3c);
    cmd(OP_IND_WR, 16'h0090, 8'h5a, 1'b0);
    cmd(OP_DIR_WR, 16'h0090, 8'h11, 1'b0);
    rd(OP_IND_RD, 16'h0090, 8'h5a);
    rd(OP_DIR_RD, 16'h0090, 8'hf6);
    chk("sfr_wdata", {sw_m, sw_d}, 16'hff11);
    // bit access above the bit area goes out as one lane of a special register
    cmd(OP_BIT_WR, 16'h0093, 8'h00, 1'b1);
    chk("sfr_bit_wr", {sw_m, sw_d}, 16'h08ff);
    rd(OP_BIT_RD, 16'h0099, 8'h01);
    chk("sfr_rd_addr", {8'h00, sr_a}, 16'h0098);
    for (int b = 0; b < 4; b++) begin
      {bank_select_hi, bank_select_lo} = b[1:0];
      cmd(OP_REG_WR, 16'h0003, 8'h40 + b[7:0], 1'b0);
    end
    for (int b = 0; b < 4; b++) rd(OP_IND_RD, 16'(b * 8 + 3), 8'h40 + b[7:0]);
    rd(OP_REG_RD, 16'h0003, 8'h43);
    $display("test data ram done");
    cmd(OP_IND_WR, 16'h0028, 8'h00, 1'b0);
    cmd(OP_BIT_WR, 16'h0042, 8'h00, 1'b1);
    rd(OP_IND_RD, 16'h0028, 8'h04);
    rd(OP_BIT_RD, 16'h0042, 8'h01);
    rd(OP_BIT_RD, 16'h0043, 8'h00);
    cmd(OP_IND_WR, 16'h002f, 8'hff, 1'b0);
    cmd(OP_BIT_WR, 16'h007f, 8'h00, 1'b0);
    rd(OP_IND_RD, 16'h002f, 8'h7f);
    $display("test bit area done");
    // extended ram: pointer picks the address, upper bits fold away
    dp0 = 16'h0005;
    dp1 = 16'h0405;
    cmd(OP_XR_WR, 16'h0000, 8'h77, 1'b0);
    dp_sel = 1;
    rd(OP_XR_RD, 16'h0000, 8'h77);
    dp1 = 16'h03ff;
    cmd(OP_XR_WR, 16'h0000, 8'h99, 1'b0);
    dp_sel = 0;
    dp0 = 16'hfbff;
    rd(OP_XR_RD, 16'h0000, 8'h99);
    $display("test extended ram done");
    dbg(14'h0100, 8'he5);
    dbg(14'h3fe0, 8'h11);
    dbg(14'h3fff, 8'hc7);
    // reset handling bytes: a jump over the vector area to the user code
    dbg(14'h0000, 8'h02);
    dbg(14'h0001, 8'h00);
    dbg(14'h0002, 8'hec);
    dp0 = 16'h0100;
    rd(OP_TABLE, 16'h0000, 8'he5);
    for (int i = 0; i < 6; i++) begin
      cmd(OP_ISP_WR, ia[i], 8'h42, 1'b0);
      chk("done_err", {15'h0000, done_err}, {15'h0000, ie[i]});
    end
    cmd(OP_JUMP, 16'h00ec, 8'h00, 1'b0);
    rd(OP_FETCH, 16'h0000, 8'h42);
    cmd(OP_JUMP, 16'h3fdf, 8'h00, 1'b0);
    rd(OP_FETCH, 16'h0000, 8'h42);
    rd(OP_FETCH, 16'h0000, 8'h11);
    cmd(OP_JUMP, 16'h3fff, 8'h00, 1'b0);
    rd(OP_FETCH, 16'h0000, 8'hc7);
    chk("fetch_addr", {2'b00, fetch_addr}, 16'h0000);
    cmd(OP_JUMP, 16'h0100, 8'h00, 1'b0);
    rd(OP_FETCH, 16'h0000, 8'he5);
    chk("fetch_addr", {2'b00, fetch_addr}, 16'h0101);
    reset_event = 1;
    @(negedge clk_sys);
    reset_event = 0;
    chk("fetch_addr", {2'b00, fetch_addr}, 16'h0000);
    rd(OP_FETCH, 16'h0000, 8'h02);
    rd(OP_FETCH, 16'h0000, 8'h00);
    rd(OP_FETCH, 16'h0000, 8'hec);
    cmd(OP_JUMP, 16'h00ec, 8'h00, 1'b0);
    chk("fetch_addr", {2'b00, fetch_addr}, 16'h00ec);
    $display("test program flash done");
    for (int i = 0; i < 19; i++) begin
      cmd(OP_IRQ, 16'(i), 8'h00, 1'b0);
      chk("vector", {2'b00, fetch_addr}, {2'b00, vec[i]});
    end
    cmd(OP_IRQ, 16'h0013, 8'h00, 1'b0);
    chk("irq_err", {15'h0000, done_err}, 16'h0001);
    chk("vector", {2'b00, fetch_addr}, {2'b00, vec[18]});
    // reset in mid-run must bring fetching back to the start
    reset_n = 0;
    repeat (2) @(negedge clk_sys);
    reset_n = 1;
    chk("fetch_addr", {2'b00, fetch_addr}, 16'h0000);
    $display("test vectors done");
    give_verdict;
  end
endmodule
